//--- hdl/fault_resp_pkg.sv
// constants and types for the per-channel fault response block
//
// Function
// - response 00 on ov or vin: force top gate high
// - response 01: run delay, then retry action
// - response 10: shut down now, then retry action
// - response 11 write flags logic fault
// - bad response byte write is discarded
// - any fault sets status, alert unless masked
// - status clears on clear, off-on, power
// - retry 000: stay off until cleared
// - retry 111: retry forever at interval
// - retry interval 120 ms to 83.88 s
// - delay field counts ten microsecond units
// - undervoltage sets three status bits, alert
// - undervoltage masked until start-up complete
// - undervoltage masked while channel inactive
// - undervoltage masked during rise and fall
package fault_resp_pkg;
	localparam int CHANNELS = 2;
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	localparam logic [7:0] OV_RESP_RESET = 8'h00;
	localparam logic [7:0] UV_RESP_RESET = 8'hB8;
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DEGLITCH = 2'h1;
	localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
	localparam logic [1:0] RESP_BAD = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_ALWAYS = 3'h7;
	localparam int CLK_HZ = 40000000;
	localparam int DELAY_UNIT_NS = 10000;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / (1000000000 / CLK_HZ);
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam logic [16:0] RETRY_MIN_MS = 17'h00078;
	localparam logic [16:0] RETRY_MAX_MS = 17'h147A8;
	localparam logic [16:0] RETRY_RESET_MS = 17'h0015E;
	// status bit positions in the per-channel status vector
	localparam int ST_OV = 0;
	localparam int ST_VIN = 1;
	localparam int ST_UV = 2;
	localparam int ST_NONE = 3;
	localparam int ST_VOUT = 4;
	localparam int ST_INPUT = 5;
	localparam int ST_W = 6;
	typedef enum logic [1:0] {RUN_ON, DELAYING, SHUT_OFF, WAIT_RETRY} chan_state_t;
endpackage : fault_resp_pkg

//--- hdl/output_fault_response.sv
// per-channel over/undervoltage fault response with status and alert
`timescale 1ns/1ps
module output_fault_response
	import fault_resp_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic [CHANNELS-1:0] WR_SEL_IN,
	input wire logic [1:0] WR_REG_IN,
	input wire logic WR_STB_IN,
	input wire logic [16:0] WR_DATA_IN,
	input wire logic CLEAR_FAULTS_IN,
	input wire logic [CHANNELS-1:0] CHAN_ON_IN,
	input wire logic [CHANNELS-1:0] OV_IN,
	input wire logic [CHANNELS-1:0] VIN_OV_IN,
	input wire logic [CHANNELS-1:0] UV_IN,
	input wire logic [CHANNELS-1:0] TON_MAX_DONE_IN,
	input wire logic [CHANNELS-1:0] TON_DELAY_DONE_IN,
	input wire logic [CHANNELS-1:0] TON_RISE_DONE_IN,
	input wire logic [CHANNELS-1:0] UV_LIMIT_REACHED_IN,
	input wire logic [CHANNELS-1:0] TOFF_FALL_IN,
	input wire logic [ST_W-1:0] ALERT_MASK_IN,
	output logic [CHANNELS-1:0] TOP_GATE_DRIVE_OUT,
	output logic [CHANNELS-1:0] OUTPUT_EN_OUT,
	output logic [CHANNELS*ST_W-1:0] STATUS_OUT,
	output logic ALERT_N_OUT,
	output logic CML_FAULT_OUT
);
	// register select codes on WR_REG_IN
	localparam logic [1:0] SEL_OV = 2'h0;
	localparam logic [1:0] SEL_VIN = 2'h1;
	localparam logic [1:0] SEL_UV = 2'h2;
	localparam logic [1:0] SEL_RETRY = 2'h3;

	typedef struct packed {
		logic [CHANNELS-1:0][7:0] ov_resp;
		logic [CHANNELS-1:0][7:0] vin_resp;
		logic [CHANNELS-1:0][7:0] uv_resp;
		logic [CHANNELS-1:0][16:0] retry_ms;
		chan_state_t [CHANNELS-1:0] state;
		logic [CHANNELS-1:0][31:0] count;
		logic [CHANNELS-1:0][16:0] ms_left;
		logic [CHANNELS-1:0] force_tg;
		logic [CHANNELS-1:0] prev_on;
		logic [CHANNELS-1:0][ST_W-1:0] status;
		logic [CHANNELS-1:0][2:0] sync_a;
		logic [CHANNELS-1:0][2:0] sync_b;
		logic [CHANNELS-1:0] on_a;
		logic [CHANNELS-1:0] on_b;
		logic [CHANNELS-1:0] en;
		logic alert_n;
		logic cml;
	} state_t;

	state_t s_reg;
	state_t s_next;

	////////////////////////////////////////////////////////////////////////
	// next-state logic for all channels
	always_comb begin
		logic [7:0] resp;
		logic [2:0] flt;
		logic fault_now;
		logic uv_live;
		logic any_alert;
		logic ov_known;
		resp = 8'h00;
		flt = 3'h0;
		fault_now = 1'b0;
		uv_live = 1'b0;
		any_alert = 1'b0;
		// output ov accepts only its listed codes: 00, 80, B8, 40-47, 78-7F
		ov_known = (WR_DATA_IN[7:0] == 8'h00) || (WR_DATA_IN[7:0] == 8'h80)
			|| (WR_DATA_IN[7:0] == 8'hB8) || (WR_DATA_IN[7:3] == 5'h08)
			|| (WR_DATA_IN[7:3] == 5'h0F);
		s_next = s_reg;
		s_next.cml = 1'b0;
		// comparator pins and the channel-on pin come from the analog side: two stages first
		for (int c = 0; c < CHANNELS; c++) begin
			s_next.sync_a[c] = {UV_IN[c], VIN_OV_IN[c], OV_IN[c]};
			s_next.sync_b[c] = s_reg.sync_a[c];
			s_next.on_a[c] = CHAN_ON_IN[c];
			s_next.on_b[c] = s_reg.on_a[c];
		end
		if (WR_STB_IN) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (WR_SEL_IN[c]) begin
					if (WR_REG_IN == SEL_RETRY) begin
						if (WR_DATA_IN >= RETRY_MIN_MS && WR_DATA_IN <= RETRY_MAX_MS)
							s_next.retry_ms[c] = WR_DATA_IN;
						else
							s_next.cml = 1'b1;
					end else if (WR_DATA_IN[RESP_HI:RESP_LO] == RESP_BAD) begin
						s_next.cml = 1'b1;
					end else if (WR_REG_IN == SEL_OV && !ov_known) begin
						s_next.cml = 1'b1;
					end else if (WR_REG_IN == SEL_OV) begin
						s_next.ov_resp[c] = WR_DATA_IN[7:0];
					end else if (WR_REG_IN == SEL_VIN) begin
						s_next.vin_resp[c] = WR_DATA_IN[7:0];
					end else begin
						s_next.uv_resp[c] = WR_DATA_IN[7:0];
					end
				end
			end
		end
		for (int c = 0; c < CHANNELS; c++) begin
			flt = s_reg.sync_b[c];
			uv_live = s_reg.on_b[c] && (s_reg.state[c] == RUN_ON) && TON_MAX_DONE_IN[c]
				&& TON_DELAY_DONE_IN[c] && TON_RISE_DONE_IN[c]
				&& UV_LIMIT_REACHED_IN[c] && !TOFF_FALL_IN[c];
			flt[2] = flt[2] & uv_live;
			s_next.prev_on[c] = s_reg.on_b[c];
			if (CLEAR_FAULTS_IN || (s_reg.on_b[c] && !s_reg.prev_on[c]))
				s_next.status[c] = '0;
			// status bits, set wins over clear
			if (flt[0]) begin
				s_next.status[c][ST_OV] = 1'b1;
				s_next.status[c][ST_VOUT] = 1'b1;
			end
			if (flt[1]) begin
				s_next.status[c][ST_VIN] = 1'b1;
				s_next.status[c][ST_NONE] = 1'b1;
				s_next.status[c][ST_INPUT] = 1'b1;
			end
			if (flt[2]) begin
				s_next.status[c][ST_UV] = 1'b1;
				s_next.status[c][ST_NONE] = 1'b1;
				s_next.status[c][ST_VOUT] = 1'b1;
			end
			// response of the first live fault not set to 00, in order ov, vin, then uv
			if (flt[0] && s_reg.ov_resp[c][RESP_HI:RESP_LO] != RESP_IGNORE)
				resp = s_reg.ov_resp[c];
			else if (flt[1] && s_reg.vin_resp[c][RESP_HI:RESP_LO] != RESP_IGNORE)
				resp = s_reg.vin_resp[c];
			else if (flt[2])
				resp = s_reg.uv_resp[c];
			else
				resp = 8'h00;
			fault_now = |flt;
			// force top gate for ov or vin with response 00
			s_next.force_tg[c] = s_reg.force_tg[c] && s_reg.on_b[c];
			if ((flt[0] && s_reg.ov_resp[c][RESP_HI:RESP_LO] == RESP_IGNORE)
				|| (flt[1] && s_reg.vin_resp[c][RESP_HI:RESP_LO] == RESP_IGNORE))
				s_next.force_tg[c] = 1'b1;
			if (!s_reg.on_b[c]) begin
				// commanded off ends any retry or latch-off
				s_next.state[c] = RUN_ON;
				s_next.count[c] = '0;
			end else begin
				case (s_reg.state[c])
					RUN_ON: begin
						// deglitch delay in 10 us units
						if (fault_now && resp[RESP_HI:RESP_LO] == RESP_DEGLITCH) begin
							s_next.state[c] = DELAYING;
							s_next.count[c] = 32'(resp[DELAY_HI:DELAY_LO]) * DELAY_UNIT_CYC;
						end else if (fault_now && resp[RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
							s_next.state[c] = (resp[RETRY_HI:RETRY_LO] == RETRY_ALWAYS)
								? WAIT_RETRY : SHUT_OFF;
							s_next.count[c] = 32'(MS_CYCLES);
							s_next.ms_left[c] = s_reg.retry_ms[c];
						end
					end
					DELAYING: begin
						if (!fault_now) begin
							s_next.state[c] = RUN_ON;
						end else if (s_reg.count[c] == 32'h0) begin
							s_next.state[c] = (resp[RETRY_HI:RETRY_LO] == RETRY_ALWAYS)
								? WAIT_RETRY : SHUT_OFF;
							s_next.count[c] = 32'(MS_CYCLES);
							s_next.ms_left[c] = s_reg.retry_ms[c];
						end else begin
							s_next.count[c] = s_reg.count[c] - 32'h1;
						end
					end
					// latched off until cleared or commanded off
					SHUT_OFF: begin
						if (CLEAR_FAULTS_IN)
							s_next.state[c] = RUN_ON;
					end
					WAIT_RETRY: begin
						if (fault_now && resp[RETRY_HI:RETRY_LO] == RETRY_NONE
							&& resp[RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
							s_next.state[c] = SHUT_OFF;
						end else if (s_reg.count[c] > 32'h1) begin
							s_next.count[c] = s_reg.count[c] - 32'h1;
						end else if (s_reg.ms_left[c] > 17'h00001) begin
							s_next.ms_left[c] = s_reg.ms_left[c] - 17'h00001;
							s_next.count[c] = 32'(MS_CYCLES);
						end else begin
							s_next.state[c] = RUN_ON;
						end
					end
					default: s_next.state[c] = RUN_ON;
				endcase
			end
			// enable is registered so the pin never sees a decode glitch
			s_next.en[c] = s_next.state[c] != SHUT_OFF && s_next.state[c] != WAIT_RETRY;
			if (|(s_next.status[c] & ~ALERT_MASK_IN))
				any_alert = 1'b1;
		end
		// alert pulled low while any unmasked bit is set
		s_next.alert_n = !any_alert;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			s_reg <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				s_reg.ov_resp[c] <= OV_RESP_RESET;
				s_reg.vin_resp[c] <= OV_RESP_RESET;
				s_reg.uv_resp[c] <= UV_RESP_RESET;
				s_reg.retry_ms[c] <= RETRY_RESET_MS;
			end
			s_reg.alert_n <= 1'b1;
			s_reg.en <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			TOP_GATE_DRIVE_OUT[c] = s_reg.force_tg[c];
			OUTPUT_EN_OUT[c] = s_reg.en[c];
			STATUS_OUT[c*ST_W +: ST_W] = s_reg.status[c];
		end
		ALERT_N_OUT = s_reg.alert_n;
		CML_FAULT_OUT = s_reg.cml;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// bad write flagged
	bad_write_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		WR_STB_IN && |WR_SEL_IN && WR_REG_IN != SEL_RETRY && WR_DATA_IN[7:6] == RESP_BAD
		|=> CML_FAULT_OUT) else $error("bad response write not flagged");
	keep_setting_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		WR_STB_IN && WR_SEL_IN[0] && WR_REG_IN == SEL_OV && WR_DATA_IN[7:6] == RESP_BAD
		|=> s_reg.ov_resp[0] == $past(s_reg.ov_resp[0]))
		else $error("bad response byte was stored");
	shut_now_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		s_reg.on_b[0] && s_reg.state[0] == RUN_ON && s_reg.sync_b[0][0]
		&& s_reg.ov_resp[0][7:6] == RESP_SHUTDOWN |=> !OUTPUT_EN_OUT[0])
		else $error("output not disabled on shutdown response");
	gate_force_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		s_reg.sync_b[0][0] && s_reg.ov_resp[0][7:6] == RESP_IGNORE |=> TOP_GATE_DRIVE_OUT[0])
		else $error("top gate not forced high");
	ov_status_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		s_reg.sync_b[0][0] && !ALERT_MASK_IN[ST_OV]
		|=> STATUS_OUT[ST_OV] && STATUS_OUT[ST_VOUT] && !ALERT_N_OUT)
		else $error("ov status or alert missing");
	uv_masked_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		!s_reg.on_b[0] && !CLEAR_FAULTS_IN && !STATUS_OUT[ST_UV] |=> !STATUS_OUT[ST_UV])
		else $error("uv set while channel inactive");
	latch_off_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		s_reg.state[0] == SHUT_OFF && s_reg.on_b[0] && !CLEAR_FAULTS_IN
		|=> !OUTPUT_EN_OUT[0]) else $error("latched-off channel restarted");
	clear_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		CLEAR_FAULTS_IN && s_reg.sync_b[0] == 3'h0 |=> STATUS_OUT[ST_W-1:0] == '0)
		else $error("status not cleared");
	ov_code_kept_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
		s_reg.ov_resp[0] == 8'h00 || s_reg.ov_resp[0] == 8'h80 || s_reg.ov_resp[0] == 8'hB8
		|| s_reg.ov_resp[0][7:3] == 5'h08 || s_reg.ov_resp[0][7:3] == 5'h0F)
		else $error("unlisted ov response code stored");
endmodule : output_fault_response

//--- testbench/host_model.sv
// host model that issues setting writes and clear-faults pulses
`timescale 1ns/1ps
module host_model
	import fault_resp_pkg::*;
(
	input wire logic clk_in,
	output logic [CHANNELS-1:0] sel_out,
	output logic [1:0] reg_out,
	output logic stb_out,
	output logic [16:0] data_out,
	output logic clr_out
);
	// idle levels from time zero so no design input floats
	initial begin
		sel_out = '0;
		reg_out = 2'h0;
		stb_out = 1'b0;
		data_out = 17'h00000;
		clr_out = 1'b0;
	end
	// strobe lives exactly one edge; data is scrambled once released
	task automatic wr(input logic [CHANNELS-1:0] s, input logic [1:0] r, input logic [16:0] d);
		@(posedge clk_in);
		sel_out <= s;
		reg_out <= r;
		data_out <= d;
		stb_out <= 1'b1;
		@(posedge clk_in);
		stb_out <= 1'b0;
		data_out <= ~d;
	endtask : wr
	// clear-faults command as a single-cycle pulse
	task automatic clear();
		@(posedge clk_in);
		clr_out <= 1'b1;
		@(posedge clk_in);
		clr_out <= 1'b0;
	endtask : clear
endmodule : host_model

//--- testbench/testbench.sv
// self-checking bench for the channel fault response block
`timescale 1ns/1ps
module testbench;
	import fault_resp_pkg::*;
	localparam int WAIT_CYC = 20000;
	// bad writes: {target, data}; every one must be refused
	localparam logic [18:0] BAD [6] = '{19'h000C0, 19'h200FF, 19'h400C5, 19'h60077, 19'h747A9,
		19'h00088};
	logic clk;
	logic nrst;
	logic [CHANNELS-1:0] on, ov, vov, uv, tmax, tdly, trise, ulim, tfall, sel, tg, en;
	logic [ST_W-1:0] mask;
	logic [1:0] wreg;
	logic stb, clr, alert_n, cml;
	logic [16:0] wdata;
	logic [CHANNELS*ST_W-1:0] st;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_cml = 0;
	host_model host (.clk_in(clk), .sel_out(sel), .reg_out(wreg), .stb_out(stb),
		.data_out(wdata), .clr_out(clr));
	// short millisecond so retry intervals fit the run
	output_fault_response #(.MS_CYCLES(4)) DUT (.CLK_IN(clk), .NRST_IN(nrst),
		.WR_SEL_IN(sel), .WR_REG_IN(wreg), .WR_STB_IN(stb), .WR_DATA_IN(wdata),
		.CLEAR_FAULTS_IN(clr), .CHAN_ON_IN(on), .OV_IN(ov), .VIN_OV_IN(vov), .UV_IN(uv),
		.TON_MAX_DONE_IN(tmax), .TON_DELAY_DONE_IN(tdly), .TON_RISE_DONE_IN(trise),
		.UV_LIMIT_REACHED_IN(ulim), .TOFF_FALL_IN(tfall), .ALERT_MASK_IN(mask),
		.TOP_GATE_DRIVE_OUT(tg), .OUTPUT_EN_OUT(en), .STATUS_OUT(st),
		.ALERT_N_OUT(alert_n), .CML_FAULT_OUT(cml));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// wait n edges, then sample at the settled falling edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wt
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////////////////////
	// clock, pulse counter and watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) if (cml === 1'b1) n_cml <= n_cml + 1;
	initial begin
		wt(WAIT_CYC);
		n_mismatch++;
		conclude();
	end
	// main sequence; both channels start on with start-up complete
	initial begin
		nrst = 1'b0;
		{ov, vov, uv, tfall} = '0;
		{on, tmax, tdly, trise, ulim} = 10'h3FF;
		mask = 6'h00;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		wt(2);
		chk(17'(st), 17'h00000);
		chk(17'(alert_n), 17'h00001);
		chk(17'(en), 17'h00003);
		chk(17'(tg), 17'h00000);
		for (int i = 0; i < 6; i++) host.wr(2'h1, BAD[i][18:17], BAD[i][16:0]);
		host.wr(2'h3, 2'h3, 17'h147A8);
		host.wr(2'h3, 2'h3, 17'h00078);
		wt(2);
		chk(n_cml[16:0], 17'h00006);
		// refused writes kept the reset response, so the gate is forced
		@(posedge clk) ov <= 2'h1;
		wt(5);
		chk(17'(tg), 17'h00001);
		chk(17'(en), 17'h00003);
		chk(17'(st), 17'h00011);
		chk(17'(alert_n), 17'h00000);
		@(posedge clk) ov <= 2'h0;
		wt(5);
		chk(17'(st), 17'h00011);
		host.clear();
		wt(3);
		chk(17'(st), 17'h00000);
		// shutdown without retry stays off past the retry interval
		host.wr(2'h1, 2'h0, 17'h00080);
		@(posedge clk) ov <= 2'h1;
		@(posedge clk) ov <= 2'h0;
		wt(5);
		chk(17'(en), 17'h00002);
		wt(700);
		chk(17'(en), 17'h00002);
		host.clear();
		wt(3);
		chk(17'(en), 17'h00003);
		// retry forever: back on one interval after detection
		host.wr(2'h1, 2'h0, 17'h000B8);
		@(posedge clk) ov <= 2'h1;
		@(posedge clk) ov <= 2'h0;
		wt(6);
		chk(17'(en), 17'h00002);
		wt(400);
		chk(17'(en), 17'h00002);
		wt(150);
		chk(17'(en), 17'h00003);
		host.clear();
		// deglitch one unit: a short fault is ridden through
		host.wr(2'h1, 2'h0, 17'h00041);
		@(posedge clk) ov <= 2'h1;
		wt(200);
		@(posedge clk) ov <= 2'h0;
		wt(600);
		chk(17'(en), 17'h00003);
		chk(17'(st[5:0]), 17'h00011);
		@(posedge clk) ov <= 2'h1;
		wt(300);
		chk(17'(en), 17'h00003);
		wt(200);
		chk(17'(en), 17'h00002);
		@(posedge clk) ov <= 2'h0;
		on <= 2'h2;
		wt(5);
		@(posedge clk) on <= 2'h3;
		wt(5);
		chk(17'(st), 17'h00000);
		chk(17'(en), 17'h00003);
		// undervoltage on channel one under each masking condition in turn
		@(posedge clk) uv <= 2'h2;
		tmax <= 2'h1;
		wt(8);
		chk(17'(st), 17'h00000);
		@(posedge clk) tmax <= 2'h3;
		tdly <= 2'h1;
		wt(8);
		chk(17'(st), 17'h00000);
		@(posedge clk) tdly <= 2'h3;
		ulim <= 2'h1;
		wt(8);
		chk(17'(st), 17'h00000);
		@(posedge clk) ulim <= 2'h3;
		trise <= 2'h1;
		wt(8);
		chk(17'(st), 17'h00000);
		@(posedge clk) trise <= 2'h3;
		tfall <= 2'h2;
		wt(8);
		chk(17'(st), 17'h00000);
		// drop the channel under the fall mask: the on sync lags two edges
		@(posedge clk) on <= 2'h1;
		wt(3);
		@(posedge clk) tfall <= 2'h0;
		wt(8);
		chk(17'(st), 17'h00000);
		@(posedge clk) on <= 2'h3;
		wt(8);
		chk(17'(st), 17'h00700);
		chk(17'(alert_n), 17'h00000);
		chk(17'(en), 17'h00001);
		@(posedge clk) uv <= 2'h0;
		host.clear();
		wt(3);
		chk(17'(st), 17'h00000);
		// input ov set to no retry ends the channel-one retry wait for good
		host.wr(2'h2, 2'h1, 17'h00080);
		@(posedge clk) mask <= 6'h3F;
		vov <= 2'h2;
		wt(6);
		chk(17'(st), 17'h00A80);
		chk(17'(alert_n), 17'h00001);
		chk(17'(en), 17'h00001);
		@(posedge clk) mask <= 6'h00;
		wt(3);
		chk(17'(alert_n), 17'h00000);
		@(posedge clk) vov <= 2'h0;
		wt(500);
		chk(17'(en), 17'h00001);
		// supply cycle: reset wipes status and re-enables both channels
		@(posedge clk) nrst <= 1'b0;
		wt(2);
		chk(17'(st), 17'h00000);
		chk(17'(en), 17'h00003);
		chk(17'(tg), 17'h00000);
		chk(17'(alert_n), 17'h00001);
		@(posedge clk) nrst <= 1'b1;
		wt(3);
		chk(17'(st), 17'h00000);
		chk(17'(en), 17'h00003);
		conclude();
	end
endmodule : testbench
